// File: logic/gprsfr_core.sv
// general-purpose register file and special function register window
// assumes the cpu datapath drives requests synchronous to core_clk
// and that peripherals feed their read-only values on plain inputs
`timescale 1ns/1ps

module gprsfr_core #(
  parameter logic [7:0] SFR_UNMAPPED_VAL = 8'h00
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        gpr_we,
  input  wire logic        gpr_wr_wide,
  input  wire logic [2:0]  gpr_wr_index,
  input  wire logic [15:0] gpr_wr_data,
  input  wire logic        gpr_rd,
  input  wire logic        gpr_rd_wide,
  input  wire logic [2:0]  gpr_rd_index,
  output logic      [15:0] gpr_rd_data_ff,
  input  wire logic        sfr_req,
  input  wire logic        sfr_we,
  input  wire logic [15:0] sfr_addr,
  input  wire logic [1:0]  sfr_width,
  input  wire logic [2:0]  sfr_bit,
  input  wire logic        sfr_short_direct,
  input  wire logic [15:0] sfr_wdata,
  output logic             sfr_ack_ff,
  output logic             sfr_hit_ff,
  output logic             sfr_err_ff,
  output logic      [15:0] sfr_rdata_ff,
  input  wire logic        input_only_port_bit,
  input  wire logic [15:0] wide_timer_count,
  input  wire logic [9:0]  conversion_in,
  input  wire logic [7:0]  reset_source_in,
  output logic      [7:0]  port_latch_2_ff,
  output logic      [7:0]  port_direction_2_ff,
  output logic      [7:0]  pullup_option_2_ff,
  output logic      [7:0]  watchdog_mode_ff,
  output logic      [7:0]  watchdog_enable_ff,
  output logic      [15:0] capcomp_a_ff,
  output logic      [15:0] capcomp_b_ff
);

  typedef struct packed {
    logic [7:0][7:0]   gpr;
    logic [255:0][7:0] img;
    logic              cause_done;
    logic              ack;
    logic              hit;
    logic              err;
    logic [15:0]       rdata;
    logic [15:0]       grd;
  } gprsfr_state_t;

  function automatic gprsfr_pkg::gprsfr_attr_t sfr_attr(
    input logic [15:0] a
  );
    case (a)
      gprsfr_pkg::ADDR_PORT_LATCH_2, gprsfr_pkg::ADDR_PORT_LATCH_3,
      gprsfr_pkg::ADDR_PORT_LATCH_4, gprsfr_pkg::ADDR_PORT_LATCH_12,
      gprsfr_pkg::ADDR_PORT_DIR_2, gprsfr_pkg::ADDR_PORT_DIR_3,
      gprsfr_pkg::ADDR_PORT_DIR_4, gprsfr_pkg::ADDR_PORT_DIR_12,
      gprsfr_pkg::ADDR_PULLUP_2, gprsfr_pkg::ADDR_PULLUP_3,
      gprsfr_pkg::ADDR_PULLUP_4, gprsfr_pkg::ADDR_PULLUP_12,
      gprsfr_pkg::ADDR_WT_MODE_CTL, gprsfr_pkg::ADDR_WT_PRESCALER,
      gprsfr_pkg::ADDR_WT_CC_CTL, gprsfr_pkg::ADDR_WT_OUT_CTL,
      gprsfr_pkg::ADDR_TMH_MODE:
        sfr_attr = 6'h3e;
      gprsfr_pkg::ADDR_PORT_LATCH_13:
        sfr_attr = 6'h2e;
      gprsfr_pkg::ADDR_TMH_CMP_LOW, gprsfr_pkg::ADDR_TMH_CMP_HIGH,
      gprsfr_pkg::ADDR_WDT_MODE, gprsfr_pkg::ADDR_WDT_ENABLE,
      gprsfr_pkg::ADDR_LV_MODE, gprsfr_pkg::ADDR_LV_LEVEL,
      gprsfr_pkg::ADDR_SLOW_OSC, gprsfr_pkg::ADDR_FAST_OSC:
        sfr_attr = 6'h3a;
      gprsfr_pkg::ADDR_RESET_CAUSE, gprsfr_pkg::ADDR_CONV_UPPER:
        sfr_attr = 6'h32;
      gprsfr_pkg::ADDR_WIDE_COUNT, gprsfr_pkg::ADDR_CONV_FULL:
        sfr_attr = 6'h31;
      gprsfr_pkg::ADDR_CAPCOMP_A, gprsfr_pkg::ADDR_CAPCOMP_B:
        sfr_attr = 6'h39;
      // odd halves of word registers: mapped, but no width allowed
      gprsfr_pkg::ADDR_WIDE_COUNT | 16'h0001,
      gprsfr_pkg::ADDR_CAPCOMP_A | 16'h0001,
      gprsfr_pkg::ADDR_CAPCOMP_B | 16'h0001,
      gprsfr_pkg::ADDR_CONV_FULL | 16'h0001:
        sfr_attr = 6'h20;
      default:
        sfr_attr = 6'h00;
    endcase
  endfunction : sfr_attr

  function automatic logic [255:0][7:0] sfr_reset_img();
    logic [255:0][7:0] r;
    r = '0;
    r[gprsfr_pkg::ADDR_PORT_LATCH_2[7:0]]  = gprsfr_pkg::PORT_LATCH_RST;
    r[gprsfr_pkg::ADDR_PORT_LATCH_3[7:0]]  = gprsfr_pkg::PORT_LATCH_RST;
    r[gprsfr_pkg::ADDR_PORT_LATCH_4[7:0]]  = gprsfr_pkg::PORT_LATCH_RST;
    r[gprsfr_pkg::ADDR_PORT_LATCH_12[7:0]] = gprsfr_pkg::PORT_LATCH_RST;
    r[gprsfr_pkg::ADDR_PORT_LATCH_13[7:0]] = gprsfr_pkg::PORT_LATCH_RST;
    r[gprsfr_pkg::ADDR_PORT_DIR_2[7:0]]    = gprsfr_pkg::PORT_DIR_RST;
    r[gprsfr_pkg::ADDR_PORT_DIR_3[7:0]]    = gprsfr_pkg::PORT_DIR_RST;
    r[gprsfr_pkg::ADDR_PORT_DIR_4[7:0]]    = gprsfr_pkg::PORT_DIR_RST;
    r[gprsfr_pkg::ADDR_PORT_DIR_12[7:0]]   = gprsfr_pkg::PORT_DIR_RST;
    r[gprsfr_pkg::ADDR_PULLUP_2[7:0]]      = gprsfr_pkg::PULLUP_RST;
    r[gprsfr_pkg::ADDR_WDT_MODE[7:0]]      = gprsfr_pkg::WDT_MODE_RST;
    r[gprsfr_pkg::ADDR_WDT_ENABLE[7:0]]    = gprsfr_pkg::WDT_ENABLE_RST;
    r[gprsfr_pkg::ADDR_RESET_CAUSE[7:0]]   = gprsfr_pkg::CAUSE_RST;
    return r;
  endfunction : sfr_reset_img

  // byte slot of a pair member; hi selects the odd register
  function automatic logic [2:0] pair_slot(
    input logic [1:0] pair,
    input logic       hi
  );
    return {pair, hi};
  endfunction : pair_slot

  localparam logic [255:0][7:0] IMG_RST = sfr_reset_img();

  gprsfr_state_t s_ff;
  gprsfr_state_t nxt_s;

  gprsfr_pkg::gprsfr_attr_t at;
  logic [7:0] lo;
  logic [7:0] hi_lo;
  logic [7:0] rbyte;
  logic       wok;
  logic       dok;
  logic       ok;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = 1'b0;
    nxt_s.hit = 1'b0;
    nxt_s.err = 1'b0;
    nxt_s.rdata = '0;
    nxt_s.grd = s_ff.grd;
    lo = sfr_addr[7:0];
    hi_lo = {sfr_addr[7:1], 1'b1};
    at = sfr_attr(sfr_addr);
    wok = 1'b0;
    dok = 1'b0;
    ok = 1'b0;
    rbyte = s_ff.img[lo];
    if (lo == gprsfr_pkg::ADDR_PORT_LATCH_3[7:0]) begin
      rbyte[gprsfr_pkg::INPUT_ONLY_BIT] = input_only_port_bit;
    end
    // hardware-owned read-only values follow their sources
    nxt_s.img[gprsfr_pkg::ADDR_WIDE_COUNT[7:0]] =
      wide_timer_count[7:0];
    nxt_s.img[gprsfr_pkg::ADDR_WIDE_COUNT[7:0] + 8'h01] =
      wide_timer_count[15:8];
    nxt_s.img[gprsfr_pkg::ADDR_CONV_FULL[7:0]] = conversion_in[7:0];
    nxt_s.img[gprsfr_pkg::ADDR_CONV_FULL[7:0] + 8'h01] =
      {6'h00, conversion_in[9:8]};
    nxt_s.img[gprsfr_pkg::ADDR_CONV_UPPER[7:0]] = conversion_in[9:2];
    // cause is caught one edge after release, never under reset
    if (!s_ff.cause_done) begin
      nxt_s.img[gprsfr_pkg::ADDR_RESET_CAUSE[7:0]] =
        reset_source_in;
      nxt_s.cause_done = 1'b1;
    end
    if (sfr_req) begin
      nxt_s.ack = 1'b1;
      nxt_s.hit = (sfr_addr[15:8] == gprsfr_pkg::SFR_PAGE);
      // symbol and address forms arrive as the same address
      case (sfr_width)
        gprsfr_pkg::ACC_BIT:  wok = at.b1;
        gprsfr_pkg::ACC_BYTE: wok = at.b8;
        gprsfr_pkg::ACC_WORD: wok = at.b16 && !sfr_addr[0] &&
                                    sfr_short_direct;
        default:              wok = 1'b0;
      endcase
      dok = sfr_we ? at.wr : at.rd;
      ok = nxt_s.hit && at.impl && wok && dok;
      nxt_s.err = !ok;
      if (ok && sfr_we) begin
        case (sfr_width)
          gprsfr_pkg::ACC_BIT:
            nxt_s.img[lo][sfr_bit] = sfr_wdata[0];
          gprsfr_pkg::ACC_WORD: begin
            nxt_s.img[lo] = sfr_wdata[7:0];
            nxt_s.img[hi_lo] = sfr_wdata[15:8];
          end
          default:
            nxt_s.img[lo] = sfr_wdata[7:0];
        endcase
      end
      if (!sfr_we) begin
        if (ok) begin
          case (sfr_width)
            gprsfr_pkg::ACC_BIT:
              nxt_s.rdata = {15'h0000, rbyte[sfr_bit]};
            gprsfr_pkg::ACC_WORD:
              nxt_s.rdata = {s_ff.img[hi_lo], rbyte};
            default:
              nxt_s.rdata = {8'h00, rbyte};
          endcase
        end else if (nxt_s.hit && !at.impl) begin
          nxt_s.rdata = {8'h00, SFR_UNMAPPED_VAL};
        end
      end
    end
    // register file: reads see the value before a same-cycle write
    if (gpr_rd) begin
      if (gpr_rd_wide) begin
        nxt_s.grd = {s_ff.gpr[pair_slot(gpr_rd_index[1:0], 1'b1)],
                     s_ff.gpr[pair_slot(gpr_rd_index[1:0], 1'b0)]};
      end else begin
        nxt_s.grd = {8'h00, s_ff.gpr[gpr_rd_index]};
      end
    end
    if (gpr_we) begin
      if (gpr_wr_wide) begin
        nxt_s.gpr[pair_slot(gpr_wr_index[1:0], 1'b0)] =
          gpr_wr_data[7:0];
        nxt_s.gpr[pair_slot(gpr_wr_index[1:0], 1'b1)] =
          gpr_wr_data[15:8];
      end else begin
        nxt_s.gpr[gpr_wr_index] = gpr_wr_data[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '{gpr: '0, img: IMG_RST, cause_done: 1'b0, ack: 1'b0,
                hit: 1'b0, err: 1'b0, rdata: 16'h0000,
                grd: 16'h0000};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign gpr_rd_data_ff = s_ff.grd;
  assign sfr_ack_ff = s_ff.ack;
  assign sfr_hit_ff = s_ff.hit;
  assign sfr_err_ff = s_ff.err;
  assign sfr_rdata_ff = s_ff.rdata;
  assign port_latch_2_ff = s_ff.img[gprsfr_pkg::ADDR_PORT_LATCH_2[7:0]];
  assign port_direction_2_ff = s_ff.img[gprsfr_pkg::ADDR_PORT_DIR_2[7:0]];
  assign pullup_option_2_ff = s_ff.img[gprsfr_pkg::ADDR_PULLUP_2[7:0]];
  assign watchdog_mode_ff = s_ff.img[gprsfr_pkg::ADDR_WDT_MODE[7:0]];
  assign watchdog_enable_ff = s_ff.img[gprsfr_pkg::ADDR_WDT_ENABLE[7:0]];
  assign capcomp_a_ff = {s_ff.img[gprsfr_pkg::ADDR_CAPCOMP_A[7:0] + 8'h01],
                         s_ff.img[gprsfr_pkg::ADDR_CAPCOMP_A[7:0]]};
  assign capcomp_b_ff = {s_ff.img[gprsfr_pkg::ADDR_CAPCOMP_B[7:0] + 8'h01],
                         s_ff.img[gprsfr_pkg::ADDR_CAPCOMP_B[7:0]]};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_pair_write;
    gpr_we && gpr_wr_wide;
  endsequence

  sequence s_pair_readback;
    gpr_rd && gpr_rd_wide && !gpr_we &&
    gpr_rd_index[1:0] == $past(gpr_wr_index[1:0]);
  endsequence

  property p_gpr_byte;
    gpr_we && !gpr_wr_wide |=>
      s_ff.gpr[$past(gpr_wr_index)] == $past(gpr_wr_data[7:0]);
  endproperty
  a_gpr_byte: assert property (p_gpr_byte)
    else $error("byte register write lost");

  property p_gpr_pair;
    s_pair_write ##1 s_pair_readback |=>
      gpr_rd_data_ff == $past(gpr_wr_data, 2);
  endproperty
  a_gpr_pair: assert property (p_gpr_pair)
    else $error("pair readback differs from pair write");

  property p_gpr_alias;
    s_pair_write |=>
      s_ff.gpr[{$past(gpr_wr_index[1:0]), 1'b1}] ==
      $past(gpr_wr_data[15:8]);
  endproperty
  a_gpr_alias: assert property (p_gpr_alias)
    else $error("pair upper byte not in odd byte register");

  property p_window;
    sfr_req |=> sfr_ack_ff &&
      sfr_hit_ff == ($past(sfr_addr[15:8]) == 8'hff);
  endproperty
  a_window: assert property (p_window)
    else $error("window decode wrong");

  property p_ro_write;
    sfr_req && sfr_we && s_ff.cause_done &&
    sfr_addr == gprsfr_pkg::ADDR_RESET_CAUSE |=>
      sfr_err_ff && $stable(s_ff.img[8'h54]);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only register was written");

  property p_reset_vals;
    !s_ff.cause_done |->
      watchdog_mode_ff == 8'h67 && watchdog_enable_ff == 8'h9a &&
      capcomp_a_ff == 16'h0000 && capcomp_b_ff == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("watchdog or timer reset value wrong");

  property p_port_reset;
    !s_ff.cause_done |->
      port_latch_2_ff == 8'h00 && port_direction_2_ff == 8'hff &&
      pullup_option_2_ff == 8'h00;
  endproperty
  a_port_reset: assert property (p_port_reset)
    else $error("port reset value wrong");

  property p_count_word;
    sfr_req && sfr_addr == gprsfr_pkg::ADDR_WIDE_COUNT &&
    sfr_width != gprsfr_pkg::ACC_WORD |=> sfr_err_ff;
  endproperty
  a_count_word: assert property (p_count_word)
    else $error("timer count taken at a non-word width");

  property p_byte_only;
    sfr_req && sfr_we && sfr_width == gprsfr_pkg::ACC_BIT &&
    sfr_addr == gprsfr_pkg::ADDR_WDT_MODE |=>
      sfr_err_ff && $stable(watchdog_mode_ff);
  endproperty
  a_byte_only: assert property (p_byte_only)
    else $error("bit write reached a byte-only register");

  property p_cause;
    !s_ff.cause_done |=> s_ff.img[8'h54] == $past(reset_source_in);
  endproperty
  a_cause: assert property (p_cause)
    else $error("reset cause not captured");

  property p_pin_bit;
    sfr_req && !sfr_we && sfr_width == gprsfr_pkg::ACC_BYTE &&
    sfr_addr == gprsfr_pkg::ADDR_PORT_LATCH_3 |=>
      sfr_rdata_ff[4] == $past(input_only_port_bit);
  endproperty
  a_pin_bit: assert property (p_pin_bit)
    else $error("input-only bit not read from pin");

  property p_short_direct;
    sfr_req && sfr_width == gprsfr_pkg::ACC_WORD &&
    !sfr_short_direct |=> sfr_err_ff;
  endproperty
  a_short_direct: assert property (p_short_direct)
    else $error("word access outside short direct mode taken");

  property p_unmapped;
    sfr_req && !sfr_we && sfr_addr == 16'hff00 |=>
      sfr_err_ff && sfr_rdata_ff == {8'h00, SFR_UNMAPPED_VAL};
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unimplemented address read value wrong");

  property p_byte_write;
    sfr_req && sfr_we && sfr_width == gprsfr_pkg::ACC_BYTE &&
    sfr_addr == gprsfr_pkg::ADDR_WDT_ENABLE |=>
      !sfr_err_ff && watchdog_enable_ff == $past(sfr_wdata[7:0]);
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write by address not stored");

endmodule : gprsfr_core

// File: logic/gprsfr_pkg.sv
// constants for the cpu register file and special function window
// assumes an 8-bit cpu datapath with a 16-bit data address space
package gprsfr_pkg;

  localparam int GPR_NUM = 8;
  localparam logic [7:0] SFR_PAGE = 8'hff;

  // access width codes on the sfr port
  localparam logic [1:0] ACC_BIT  = 2'h0;
  localparam logic [1:0] ACC_BYTE = 2'h1;
  localparam logic [1:0] ACC_WORD = 2'h2;

  // word pair indices by function name
  localparam logic [1:0] ACCUMULATOR_PAIR = 2'h0;
  localparam logic [1:0] SECOND_PAIR      = 2'h1;
  localparam logic [1:0] THIRD_PAIR       = 2'h2;
  localparam logic [1:0] FOURTH_PAIR      = 2'h3;

  localparam logic [15:0] ADDR_PORT_LATCH_2  = 16'hff02;
  localparam logic [15:0] ADDR_PORT_LATCH_3  = 16'hff03;
  localparam logic [15:0] ADDR_PORT_LATCH_4  = 16'hff04;
  localparam logic [15:0] ADDR_PORT_LATCH_12 = 16'hff0c;
  localparam logic [15:0] ADDR_PORT_LATCH_13 = 16'hff0d;
  localparam logic [15:0] ADDR_TMH_CMP_LOW   = 16'hff0e;
  localparam logic [15:0] ADDR_TMH_CMP_HIGH  = 16'hff0f;
  localparam logic [15:0] ADDR_WIDE_COUNT    = 16'hff12;
  localparam logic [15:0] ADDR_CAPCOMP_A     = 16'hff14;
  localparam logic [15:0] ADDR_CAPCOMP_B     = 16'hff16;
  localparam logic [15:0] ADDR_CONV_FULL     = 16'hff18;
  localparam logic [15:0] ADDR_CONV_UPPER    = 16'hff1a;
  localparam logic [15:0] ADDR_PORT_DIR_2    = 16'hff22;
  localparam logic [15:0] ADDR_PORT_DIR_3    = 16'hff23;
  localparam logic [15:0] ADDR_PORT_DIR_4    = 16'hff24;
  localparam logic [15:0] ADDR_PORT_DIR_12   = 16'hff2c;
  localparam logic [15:0] ADDR_PULLUP_2      = 16'hff32;
  localparam logic [15:0] ADDR_PULLUP_3      = 16'hff33;
  localparam logic [15:0] ADDR_PULLUP_4      = 16'hff34;
  localparam logic [15:0] ADDR_PULLUP_12     = 16'hff3c;
  localparam logic [15:0] ADDR_WDT_MODE      = 16'hff48;
  localparam logic [15:0] ADDR_WDT_ENABLE    = 16'hff49;
  localparam logic [15:0] ADDR_LV_MODE       = 16'hff50;
  localparam logic [15:0] ADDR_LV_LEVEL      = 16'hff51;
  localparam logic [15:0] ADDR_RESET_CAUSE   = 16'hff54;
  localparam logic [15:0] ADDR_SLOW_OSC      = 16'hff58;
  localparam logic [15:0] ADDR_FAST_OSC      = 16'hff5a;
  localparam logic [15:0] ADDR_WT_MODE_CTL   = 16'hff60;
  localparam logic [15:0] ADDR_WT_PRESCALER  = 16'hff61;
  localparam logic [15:0] ADDR_WT_CC_CTL     = 16'hff62;
  localparam logic [15:0] ADDR_WT_OUT_CTL    = 16'hff63;
  localparam logic [15:0] ADDR_TMH_MODE      = 16'hff70;

  localparam int INPUT_ONLY_BIT = 4;

  localparam logic [7:0]  PORT_LATCH_RST = 8'h00;
  localparam logic [7:0]  PORT_DIR_RST   = 8'hff;
  localparam logic [7:0]  PULLUP_RST     = 8'h00;
  localparam logic [7:0]  WDT_MODE_RST   = 8'h67;
  localparam logic [7:0]  WDT_ENABLE_RST = 8'h9a;
  localparam logic [7:0]  CAUSE_RST      = 8'h00;
  localparam logic [15:0] WIDE_RST       = 16'h0000;

  // per-register attributes
  typedef struct packed {
    logic impl;
    logic rd;
    logic wr;
    logic b1;
    logic b8;
    logic b16;
  } gprsfr_attr_t;

endpackage : gprsfr_pkg

// File: tb/gprsfr_feed_model.sv
// peripheral model feeding the special register window
// assumes the bench sets the pin level; the other feeds are fixed
`timescale 1ns/1ps

module gprsfr_feed_model #(
  parameter logic [15:0] COUNT_VAL = 16'h1234,
  parameter logic [9:0]  CONV_VAL  = 10'h2d5,
  parameter logic [7:0]  CAUSE_VAL = 8'h01
) (
  input  wire logic        pin_level,
  output logic      [15:0] wide_timer_count,
  output logic      [9:0]  conversion_in,
  output logic      [7:0]  reset_source_in,
  output logic             input_only_port_bit
);
  // fixed feeds: reads can be predicted without guessing copy latency
  assign wide_timer_count    = COUNT_VAL;
  assign conversion_in       = CONV_VAL;
  assign reset_source_in     = CAUSE_VAL;
  assign input_only_port_bit = pin_level;
endmodule : gprsfr_feed_model

// File: tb/test_gpr_file_and_sfr_space_map.sv
// self-checking bench for the register file and special register window
// assumes one-cycle answers and a fixed peripheral feed model
`timescale 1ns/1ps

module test_gpr_file_and_sfr_space_map;
  localparam logic [1:0] BI       = gprsfr_pkg::ACC_BIT;
  localparam logic [1:0] BY       = gprsfr_pkg::ACC_BYTE;
  localparam logic [1:0] WD       = gprsfr_pkg::ACC_WORD;
  localparam logic [7:0] UNMAPPED = 8'h5e;
  logic        core_clk, arst_n, gpr_we, gpr_wr_wide, gpr_rd, gpr_rd_wide;
  logic        sfr_req, sfr_we, sfr_short_direct, pin_level, pin_bit;
  logic [2:0]  gpr_wr_index, gpr_rd_index, sfr_bit;
  logic [1:0]  sfr_width;
  logic [15:0] gpr_wr_data, sfr_addr, sfr_wdata, gpr_rd_data_ff, sfr_rdata_ff;
  logic [15:0] count, capcomp_a_ff, capcomp_b_ff;
  logic        sfr_ack_ff, sfr_hit_ff, sfr_err_ff;
  logic [9:0]  conv;
  logic [7:0]  cause, port_latch_2_ff, port_direction_2_ff, pullup_option_2_ff;
  logic [7:0]  watchdog_mode_ff, watchdog_enable_ff;
  int          fails;
  int          total_checks;

  gprsfr_core #(.SFR_UNMAPPED_VAL(UNMAPPED)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .gpr_we(gpr_we),
    .gpr_wr_wide(gpr_wr_wide), .gpr_wr_index(gpr_wr_index),
    .gpr_wr_data(gpr_wr_data), .gpr_rd(gpr_rd), .gpr_rd_wide(gpr_rd_wide),
    .gpr_rd_index(gpr_rd_index), .gpr_rd_data_ff(gpr_rd_data_ff),
    .sfr_req(sfr_req), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
    .sfr_width(sfr_width), .sfr_bit(sfr_bit),
    .sfr_short_direct(sfr_short_direct), .sfr_wdata(sfr_wdata),
    .sfr_ack_ff(sfr_ack_ff), .sfr_hit_ff(sfr_hit_ff),
    .sfr_err_ff(sfr_err_ff), .sfr_rdata_ff(sfr_rdata_ff),
    .input_only_port_bit(pin_bit), .wide_timer_count(count),
    .conversion_in(conv), .reset_source_in(cause),
    .port_latch_2_ff(port_latch_2_ff),
    .port_direction_2_ff(port_direction_2_ff),
    .pullup_option_2_ff(pullup_option_2_ff),
    .watchdog_mode_ff(watchdog_mode_ff),
    .watchdog_enable_ff(watchdog_enable_ff),
    .capcomp_a_ff(capcomp_a_ff), .capcomp_b_ff(capcomp_b_ff));

  gprsfr_feed_model i_feed (
    .pin_level(pin_level), .wide_timer_count(count), .conversion_in(conv),
    .reset_source_in(cause), .input_only_port_bit(pin_bit));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check_val(input string name, input logic [15:0] seen,
                           input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check_val

  task automatic report_and_stop;
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // called at a falling edge; request stays up so calls run back to back
  task automatic acc(input logic we, input logic [15:0] a,
                     input logic [1:0] w, input logic [2:0] b,
                     input logic sd, input logic [15:0] d,
                     input logic [15:0] exp, input logic err);
    sfr_req = 1'b1;
    sfr_we = we;
    sfr_addr = a;
    sfr_width = w;
    sfr_bit = b;
    sfr_short_direct = sd;
    sfr_wdata = d;
    @(negedge core_clk);
    check_val("sfr_ack", {15'h0, sfr_ack_ff}, 16'h0001);
    check_val("sfr_hit", {15'h0, sfr_hit_ff}, {15'h0, a[15:8] == 8'hff});
    check_val("sfr_err", {15'h0, sfr_err_ff}, {15'h0, err});
    check_val("sfr_rdata", sfr_rdata_ff, exp);
  endtask : acc

  task automatic rd(input logic [15:0] a, input logic [1:0] w,
                    input logic [15:0] exp, input logic err);
    acc(1'b0, a, w, 3'h0, 1'b1, 16'h0, exp, err);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [1:0] w,
                    input logic [2:0] b, input logic [15:0] d, input logic err);
    acc(1'b1, a, w, b, 1'b1, d, 16'h0, err);
  endtask : wr

  task automatic gpr(input logic we, input logic ww, input logic [2:0] wi,
                     input logic [15:0] wd, input logic rw,
                     input logic [2:0] ri, input logic [15:0] exp);
    gpr_we = we;
    gpr_wr_wide = ww;
    gpr_wr_index = wi;
    gpr_wr_data = wd;
    gpr_rd = 1'b1;
    gpr_rd_wide = rw;
    gpr_rd_index = ri;
    @(negedge core_clk);
    check_val("gpr_rd_data", gpr_rd_data_ff, exp);
  endtask : gpr

  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    {arst_n, gpr_we, gpr_wr_wide, gpr_rd, gpr_rd_wide, pin_level} = '0;
    {sfr_req, sfr_we, sfr_short_direct, sfr_width, sfr_bit} = '0;
    {gpr_wr_index, gpr_rd_index, gpr_wr_data, sfr_addr, sfr_wdata} = '0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(negedge core_clk);
    check_val("latch2", {8'h0, port_latch_2_ff}, 16'h0000);
    check_val("dir2", {8'h0, port_direction_2_ff}, 16'h00ff);
    check_val("pull2", {8'h0, pullup_option_2_ff}, 16'h0000);
    check_val("wdt_en", {8'h0, watchdog_enable_ff}, 16'h009a);
    check_val("cc_b", capcomp_b_ff, 16'h0000);
    arst_n = 1'b1;
    @(negedge core_clk);
    rd(gprsfr_pkg::ADDR_PORT_DIR_2, BY, 16'h00ff, 1'b0);
    rd(gprsfr_pkg::ADDR_PULLUP_2, BY, 16'h0000, 1'b0);
    rd(gprsfr_pkg::ADDR_WDT_MODE, BY, 16'h0067, 1'b0);
    rd(gprsfr_pkg::ADDR_WDT_ENABLE, BY, 16'h009a, 1'b0);
    rd(gprsfr_pkg::ADDR_RESET_CAUSE, BY, 16'h0001, 1'b0);
    rd(gprsfr_pkg::ADDR_CAPCOMP_A, WD, 16'h0000, 1'b0);
    rd(gprsfr_pkg::ADDR_WIDE_COUNT, WD, 16'h1234, 1'b0);
    rd(gprsfr_pkg::ADDR_CONV_FULL, WD, 16'h02d5, 1'b0);
    rd(gprsfr_pkg::ADDR_CONV_UPPER, BY, 16'h00b5, 1'b0);
    rd(gprsfr_pkg::ADDR_WIDE_COUNT, BY, 16'h0000, 1'b1);
    wr(gprsfr_pkg::ADDR_WIDE_COUNT, WD, 3'h0, 16'hffff, 1'b1);
    wr(gprsfr_pkg::ADDR_RESET_CAUSE, BY, 3'h0, 16'h00ff, 1'b1);
    wr(gprsfr_pkg::ADDR_CAPCOMP_A, WD, 3'h0, 16'hbeef, 1'b0);
    check_val("cc_a", capcomp_a_ff, 16'hbeef);
    acc(1'b1, gprsfr_pkg::ADDR_CAPCOMP_B, WD, 3'h0, 1'b0, 16'h1111,
        16'h0, 1'b1);
    wr(gprsfr_pkg::ADDR_CAPCOMP_A, BY, 3'h0, 16'h0022, 1'b1);
    wr(16'hff15, WD, 3'h0, 16'h3333, 1'b1);
    rd(gprsfr_pkg::ADDR_CAPCOMP_A, WD, 16'hbeef, 1'b0);
    rd(gprsfr_pkg::ADDR_CAPCOMP_B, WD, 16'h0000, 1'b0);
    wr(gprsfr_pkg::ADDR_PORT_LATCH_2, BI, 3'h3, 16'h0001, 1'b0);
    rd(gprsfr_pkg::ADDR_PORT_LATCH_2, BY, 16'h0008, 1'b0);
    rd(gprsfr_pkg::ADDR_PORT_LATCH_2, 2'h3, 16'h0000, 1'b1);
    wr(gprsfr_pkg::ADDR_WDT_MODE, BY, 3'h0, 16'h0011, 1'b0);
    wr(gprsfr_pkg::ADDR_WDT_MODE, BI, 3'h0, 16'h0000, 1'b1);
    check_val("wdt_mode", {8'h0, watchdog_mode_ff}, 16'h0011);
    wr(gprsfr_pkg::ADDR_WDT_ENABLE, BY, 3'h0, 16'h00ac, 1'b0);
    check_val("wdt_en", {8'h0, watchdog_enable_ff}, 16'h00ac);
    wr(gprsfr_pkg::ADDR_TMH_CMP_LOW, BI, 3'h1, 16'h0001, 1'b1);
    wr(gprsfr_pkg::ADDR_LV_MODE, BI, 3'h1, 16'h0001, 1'b1);
    wr(gprsfr_pkg::ADDR_SLOW_OSC, BI, 3'h1, 16'h0001, 1'b1);
    wr(gprsfr_pkg::ADDR_PORT_LATCH_13, BY, 3'h0, 16'h005a, 1'b0);
    rd(gprsfr_pkg::ADDR_PORT_LATCH_13, BY, 16'h0000, 1'b1);
    wr(gprsfr_pkg::ADDR_PORT_LATCH_3, BY, 3'h0, 16'h00ff, 1'b0);
    rd(gprsfr_pkg::ADDR_PORT_LATCH_3, BY, 16'h00ef, 1'b0);
    pin_level = 1'b1;
    rd(gprsfr_pkg::ADDR_PORT_LATCH_3, BY, 16'h00ff, 1'b0);
    rd(16'hff00, BY, {8'h0, UNMAPPED}, 1'b1);
    wr(16'hff05, BY, 3'h0, 16'h0077, 1'b1);
    rd(16'hff05, BY, {8'h0, UNMAPPED}, 1'b1);
    rd(16'hffff, BY, {8'h0, UNMAPPED}, 1'b1);
    rd(16'hfeff, BY, 16'h0000, 1'b1);
    sfr_req = 1'b0;
    gpr(1'b1, 1'b1, 3'h1, 16'habcd, 1'b0, 3'h0, 16'h0000);
    gpr(1'b0, 1'b0, 3'h0, 16'h0000, 1'b0, 3'h3, 16'h00ab);
    gpr(1'b1, 1'b0, 3'h7, 16'h005a, 1'b0, 3'h2, 16'h00cd);
    gpr(1'b1, 1'b0, 3'h6, 16'h003c, 1'b0, 3'h7, 16'h005a);
    gpr(1'b1, 1'b0, 3'h6, 16'h0099, 1'b1, {1'b0, gprsfr_pkg::FOURTH_PAIR},
        16'h5a3c);
    gpr(1'b0, 1'b0, 3'h0, 16'h0000, 1'b0, 3'h6, 16'h0099);
    gpr(1'b0, 1'b0, 3'h0, 16'h0000, 1'b1, {1'b0, gprsfr_pkg::SECOND_PAIR},
        16'habcd);
    gpr(1'b1, 1'b1, {1'b0, gprsfr_pkg::THIRD_PAIR}, 16'h1357, 1'b0, 3'h5,
        16'h0000);
    gpr(1'b0, 1'b0, 3'h0, 16'h0000, 1'b1, {1'b0, gprsfr_pkg::THIRD_PAIR},
        16'h1357);
    gpr_rd = 1'b0;
    arst_n = 1'b0;
    @(negedge core_clk);
    check_val("wdt_mode", {8'h0, watchdog_mode_ff}, 16'h0067);
    check_val("latch2", {8'h0, port_latch_2_ff}, 16'h0000);
    check_val("cc_a", capcomp_a_ff, 16'h0000);
    check_val("wdt_en", {8'h0, watchdog_enable_ff}, 16'h009a);
    report_and_stop();
  end
endmodule : test_gpr_file_and_sfr_space_map
